// *** uhfir_host.v ***
`timescale 1ns/1ps
`default_nettype none
`include "uhfir_regs.vh"
// one host instance: address, enables, status, frame timer, frame number
module uhfir_host #(
  parameter        FIRST_PORT = 1,
  parameter [15:0] BASE_OFS   = 16'h0000
) (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  input  wire        tick_i,
  input  wire        wr_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        vbus_s_i,
  input  wire        id_s_i,
  input  wire        se0_s_i,
  input  wire        wake_i,
  input  wire        done_i,
  input  wire        sof_sent_i,
  output wire [15:0] addr_reg_o,
  output wire [15:0] ien_o,
  output wire [15:0] stat_o,
  output wire [15:0] reload_o,
  output wire [15:0] live_o,
  output wire [15:0] frame_o,
  output wire        irq_o,
  output wire        expire_o
);
  localparam [15:0] IEN_MASK = FIRST_PORT ? `UHFIR_IEN_MASK1 : `UHFIR_IEN_MASK2;

  reg  [`UHFIR_ADDR_W-1:0] dev_addr_ff;
  reg  [15:0]              ien_ff;
  reg  [15:0]              flag_ff;
  reg  [`UHFIR_CNT_W-1:0]  reload_ff;
  reg  [`UHFIR_CNT_W-1:0]  cnt_ff;
  reg  [`UHFIR_FRM_W-1:0]  frame_ff;
  reg                      vbus_d_ff;
  reg                      id_d_ff;
  reg                      se0_d_ff;
  reg  [`UHFIR_WARM_W-1:0] warm_ff;
  reg  [15:0]              nxt_flag;
  reg  [15:0]              ev;

  wire wr_addr   = wr_i && (addr_i == (`UHFIR_H1_ADDR + BASE_OFS));
  wire wr_ien    = wr_i && (addr_i == (`UHFIR_H1_IEN + BASE_OFS));
  wire wr_stat   = wr_i && (addr_i == (`UHFIR_H1_STAT + BASE_OFS));
  wire wr_reload = wr_i && (addr_i == (`UHFIR_H1_RELOAD + BASE_OFS));
  // expire on the tick that would reach zero, so a reload of n gives an n-tick frame
  wire expire    = tick_i && (cnt_ff <= {{(`UHFIR_CNT_W-1){1'b0}}, 1'b1});
  // pin edges ignored until synchronisers and delay flops hold real levels
  wire warm      = &warm_ff;

  // event sources; set beats a same-cycle write-one clear
  always @* begin
    ev = 16'h0000;
    ev[`UHFIR_BIT_VBUS] = FIRST_PORT && warm && (vbus_s_i != vbus_d_ff);
    ev[`UHFIR_BIT_ID]   = FIRST_PORT && warm && (id_s_i != id_d_ff);
    ev[`UHFIR_BIT_SOF]  = expire;
    ev[`UHFIR_BIT_WAKE] = wake_i;
    ev[`UHFIR_BIT_CONN] = warm && (se0_s_i != se0_d_ff);
    ev[`UHFIR_BIT_DONE] = done_i;
    nxt_flag = flag_ff;
    if (wr_stat) begin
      nxt_flag = flag_ff & ~wdata_i;
    end
    nxt_flag = (nxt_flag | ev) & IEN_MASK;
  end

  // register writes, frame counter and frame number
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dev_addr_ff <= {`UHFIR_ADDR_W{1'b0}};
      ien_ff      <= 16'h0000;
      flag_ff     <= 16'h0000;
      reload_ff   <= `UHFIR_RELOAD_RST;
      cnt_ff      <= `UHFIR_RELOAD_RST;
      frame_ff    <= {`UHFIR_FRM_W{1'b0}};
      vbus_d_ff   <= 1'b0;
      id_d_ff     <= 1'b0;
      se0_d_ff    <= 1'b0;
      warm_ff     <= {`UHFIR_WARM_W{1'b0}};
    end else begin
      if (!warm) begin
        warm_ff <= warm_ff + 1'b1;
      end
      vbus_d_ff <= vbus_s_i;
      id_d_ff   <= id_s_i;
      se0_d_ff  <= se0_s_i;
      flag_ff   <= nxt_flag;
      if (wr_addr) begin
        dev_addr_ff <= wdata_i[`UHFIR_ADDR_W-1:0];
      end
      if (wr_ien) begin
        ien_ff <= wdata_i & IEN_MASK;
      end
      if (wr_reload) begin
        reload_ff <= wdata_i[`UHFIR_CNT_W-1:0];
      end
      if (expire) begin
        cnt_ff <= reload_ff;
      end else if (tick_i) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      // a reload write wins over a same-cycle sof update
      if (wr_reload) begin
        frame_ff <= {`UHFIR_FRM_W{1'b0}};
      end else if (sof_sent_i) begin
        frame_ff <= frame_ff + 1'b1;
      end
    end
  end

  assign addr_reg_o = {9'h000, dev_addr_ff};
  assign ien_o      = ien_ff;
  assign stat_o     = {flag_ff[15:3], se0_s_i, flag_ff[1:0]};
  assign reload_o   = {2'b00, reload_ff};
  assign live_o     = {2'b00, cnt_ff};
  assign frame_o    = {5'h00, frame_ff};
  assign irq_o      = |(flag_ff & ien_ff);
  assign expire_o   = expire;
endmodule // uhfir_host
`default_nettype wire

// *** uhfir_regs.vh ***
// Summary of operation
// - target address register is write-only, holds 7-bit device address for next transaction
// - each interrupt enable bit enables its interrupt when 1, disables when 0
// - bus-voltage event on bit 15 fires on both crossings, first port only
// - id-pin event on bit 14 fires on both edges, first port only
// - frame-timer flag on bit 9 sets when frame down counter expires
// - wake flag on bit 6 sets on remote wakeup detected on port a
// - connect-change flag on bit 4 sets on se0-to-j or j-to-se0 on port a
// - status bit 2 reads 1 while port a is in se0, else 0
// - transfer-done flag on bit 0 sets on ack, nak, stall or timeout, both ports
// - writing 1 to a pending status flag clears it, writing 0 leaves it
// - 14-bit frame reload defaults to 0x2ee0 and reloads counter at zero
// - frame down counter decrements once per 12 mhz tick
// - reading frame reload returns programmed value, not live count
// - read-only register shows live 14-bit frame down counter value
// - 11-bit frame number holds next frame to send, updated after each sof
// - any write to frame reload resets frame number to zero
// - status register is reachable from parallel host port and internal processor
`ifndef UHFIR_REGS_VH
`define UHFIR_REGS_VH
`define UHFIR_H1_ADDR      16'hc088
`define UHFIR_H1_IEN       16'hc08c
`define UHFIR_H1_STAT      16'hc090
`define UHFIR_H1_RELOAD    16'hc092
`define UHFIR_H1_LIVE      16'hc094
`define UHFIR_H1_FRAME     16'hc096
`define UHFIR_H2_ADDR      16'hc0a8
`define UHFIR_H2_IEN       16'hc0ac
`define UHFIR_H2_STAT      16'hc0b0
`define UHFIR_H2_RELOAD    16'hc0b2
`define UHFIR_H2_LIVE      16'hc0b4
`define UHFIR_H2_FRAME     16'hc0b6
`define UHFIR_BIT_VBUS     15
`define UHFIR_BIT_ID       14
`define UHFIR_BIT_SOF      9
`define UHFIR_BIT_WAKE     6
`define UHFIR_BIT_CONN     4
`define UHFIR_BIT_SE0      2
`define UHFIR_BIT_DONE     0
`define UHFIR_IEN_MASK1    16'hc251
`define UHFIR_IEN_MASK2    16'h0251
`define UHFIR_RELOAD_RST   14'h2ee0
`define UHFIR_ADDR_W       7
`define UHFIR_CNT_W        14
`define UHFIR_FRM_W        11
`define UHFIR_WARM_W       2
`define UHFIR_CLK_HZ       100000000
`define UHFIR_TICK_HZ      12000000
`endif

// *** uhfir_sync2.v ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one pin level
module uhfir_sync2 (
  input  wire ref_clk_i,
  input  wire nrst_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta_ff;

  // first flop feeds only the second
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= 1'b0;
      q_o     <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule // uhfir_sync2
`default_nettype wire

// *** uhfir_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "uhfir_regs.vh"
// two host instances behind a 16-bit register port
module uhfir_top #(
  parameter CLK_HZ  = `UHFIR_CLK_HZ,
  parameter TICK_HZ = `UHFIR_TICK_HZ
) (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] rdata_o,
  output reg         rvalid_o,
  input  wire        vbus_ok_i,
  input  wire        id_pin_i,
  input  wire        se0_a1_i,
  input  wire        se0_a2_i,
  input  wire        wake_a1_i,
  input  wire        wake_a2_i,
  input  wire        done1_i,
  input  wire        done2_i,
  input  wire        sof_sent1_i,
  input  wire        sof_sent2_i,
  output reg  [6:0]  dev_addr1_o,
  output reg  [6:0]  dev_addr2_o,
  output reg         irq1_o,
  output reg         irq2_o,
  output reg         frame_exp1_o,
  output reg         frame_exp2_o
);
  // 12 mhz tick from the fast clock via fractional accumulator
  localparam [31:0] ACC_STEP = TICK_HZ;
  localparam [31:0] ACC_MOD  = CLK_HZ;
  reg  [31:0] acc_ff;
  reg         tick_ff;
  wire [32:0] acc_sum = {1'b0, acc_ff} + {1'b0, ACC_STEP};

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (acc_sum >= {1'b0, ACC_MOD}) begin
      acc_ff  <= acc_sum[31:0] - ACC_MOD;
      tick_ff <= 1'b1;
    end else begin
      acc_ff  <= acc_sum[31:0];
      tick_ff <= 1'b0;
    end
  end

  // pin levels pass two flops before use
  wire vbus_s;
  wire id_s;
  wire se0_1s;
  wire se0_2s;
  uhfir_sync2 u_s_vbus (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(vbus_ok_i), .q_o(vbus_s));
  uhfir_sync2 u_s_id   (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(id_pin_i),  .q_o(id_s));
  uhfir_sync2 u_s_se01 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(se0_a1_i),  .q_o(se0_1s));
  uhfir_sync2 u_s_se02 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(se0_a2_i),  .q_o(se0_2s));

  wire [15:0] a1, e1, s1, r1, l1, f1, a2, e2, s2, r2, l2, f2;
  wire        irq1, irq2, ex1, ex2;

  uhfir_host #(.FIRST_PORT(1), .BASE_OFS(16'h0000)) u_h1 (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tick_i(tick_ff), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .vbus_s_i(vbus_s), .id_s_i(id_s),
    .se0_s_i(se0_1s), .wake_i(wake_a1_i), .done_i(done1_i), .sof_sent_i(sof_sent1_i),
    .addr_reg_o(a1), .ien_o(e1), .stat_o(s1), .reload_o(r1), .live_o(l1),
    .frame_o(f1), .irq_o(irq1), .expire_o(ex1));

  uhfir_host #(.FIRST_PORT(0), .BASE_OFS(16'h0020)) u_h2 (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tick_i(tick_ff), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .vbus_s_i(vbus_s), .id_s_i(id_s),
    .se0_s_i(se0_2s), .wake_i(wake_a2_i), .done_i(done2_i), .sof_sent_i(sof_sent2_i),
    .addr_reg_o(a2), .ien_o(e2), .stat_o(s2), .reload_o(r2), .live_o(l2),
    .frame_o(f2), .irq_o(irq2), .expire_o(ex2));

  // read mux; address registers are write-only and read as zero
  reg [15:0] nxt_rdata;
  always @* begin
    case (addr_i)
      `UHFIR_H1_IEN:    nxt_rdata = e1;
      `UHFIR_H1_STAT:   nxt_rdata = s1;
      `UHFIR_H1_RELOAD: nxt_rdata = r1;
      `UHFIR_H1_LIVE:   nxt_rdata = l1;
      `UHFIR_H1_FRAME:  nxt_rdata = f1;
      `UHFIR_H2_IEN:    nxt_rdata = e2;
      `UHFIR_H2_STAT:   nxt_rdata = s2;
      `UHFIR_H2_RELOAD: nxt_rdata = r2;
      `UHFIR_H2_LIVE:   nxt_rdata = l2;
      `UHFIR_H2_FRAME:  nxt_rdata = f2;
      default:          nxt_rdata = 16'h0000;
    endcase
  end

  // all outputs registered
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o      <= 16'h0000;
      rvalid_o     <= 1'b0;
      dev_addr1_o  <= 7'h00;
      dev_addr2_o  <= 7'h00;
      irq1_o       <= 1'b0;
      irq2_o       <= 1'b0;
      frame_exp1_o <= 1'b0;
      frame_exp2_o <= 1'b0;
    end else begin
      rvalid_o     <= rd_i;
      if (rd_i) begin
        rdata_o <= nxt_rdata;
      end
      dev_addr1_o  <= a1[6:0];
      dev_addr2_o  <= a2[6:0];
      irq1_o       <= irq1;
      irq2_o       <= irq2;
      frame_exp1_o <= ex1;
      frame_exp2_o <= ex2;
    end
  end
endmodule // uhfir_top
`default_nettype wire

// *** uhfir_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the register port, the address and irq outputs and the expiry output of host 1 only
module uhfir_chk (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic [6:0]  dev_addr1_o,
  input wire logic [6:0]  dev_addr2_o,
  input wire logic        irq1_o,
  input wire logic        irq2_o,
  input wire logic        frame_exp1_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rvalid; rd_i |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_norv; !rd_i |=> !rvalid_o; endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_addr1;
    wr_i && addr_i == 16'hc088 |-> ##2 dev_addr1_o == $past(wdata_i[6:0], 2);
  endproperty
  a_addr1: assert property (p_addr1) else $error("address 1 not taken");
  property p_addr2;
    wr_i && addr_i == 16'hc0a8 |-> ##2 dev_addr2_o == $past(wdata_i[6:0], 2);
  endproperty
  a_addr2: assert property (p_addr2) else $error("address 2 not taken");
  // the output trails the register by one flop, so a write shows two edges later
  property p_hold1;
    !$past(wr_i && addr_i == 16'hc088, 2) |-> $stable(dev_addr1_o);
  endproperty
  a_hold1: assert property (p_hold1) else $error("address 1 moved");
  // write-only places must not leak their contents
  property p_wo; rd_i && (addr_i == 16'hc088 || addr_i == 16'hc0a8) |=> rdata_o == 16'h0000;
  endproperty
  a_wo: assert property (p_wo) else $error("address register readable");
  property p_ien1; wr_i && addr_i == 16'hc08c && wdata_i == 16'h0000 |-> ##2 !irq1_o;
  endproperty
  a_ien1: assert property (p_ien1) else $error("irq 1 not masked");
  property p_ien2; wr_i && addr_i == 16'hc0ac && wdata_i == 16'h0000 |-> ##2 !irq2_o;
  endproperty
  a_ien2: assert property (p_ien2) else $error("irq 2 not masked");
  property p_exp; frame_exp1_o |=> !frame_exp1_o; endproperty
  a_exp: assert property (p_exp) else $error("expiry longer than a cycle");
endmodule // uhfir_chk
bind uhfir_top uhfir_chk u_uhfir_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wr_i(wr_i),
  .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .dev_addr1_o(dev_addr1_o), .dev_addr2_o(dev_addr2_o), .irq1_o(irq1_o), .irq2_o(irq2_o),
  .frame_exp1_o(frame_exp1_o));
`default_nettype wire

// *** uhfir_usb_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
// attached devices: line states and transaction events
module uhfir_usb_dev (
  input  wire logic       ref_clk_i,
  output var  logic [3:0] lvl_o,
  output var  logic [5:0] pls_o
);
  // levels vbus, id, se0 a1, se0 a2; nothing attached at start
  initial lvl_o = 4'h0;
  initial pls_o = 6'h00;
  // lines move off the sampling edge so the sampler never races
  task set_lvl(input logic [3:0] v);
    @(negedge ref_clk_i) lvl_o = v;
  endtask
  // one-cycle events: wake a1/a2, done 1/2, sof 1/2
  task pulse(input logic [5:0] m);
    @(negedge ref_clk_i) pls_o = m;
    @(negedge ref_clk_i) pls_o = 6'h00;
  endtask
endmodule // uhfir_usb_dev
`default_nettype wire

// *** usb_host_frame_and_interrupt_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uhfir_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module usb_host_frame_and_interrupt_regs_bench;
  logic        ref_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic [15:0] addr_i, wdata_i, rdata_o;
  logic        rvalid_o, irq1_o, irq2_o, exp1, exp2;
  logic [6:0]  dev1, dev2;
  logic [3:0]  lvl;
  logic [5:0]  pls;
  int          n_errors = 0, check_count = 0, n = 0;
  // one tick per cycle keeps frames short
  uhfir_top #(.CLK_HZ(100), .TICK_HZ(100)) u_uhfir_top (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .vbus_ok_i(lvl[3]), .id_pin_i(lvl[2]),
    .se0_a1_i(lvl[1]), .se0_a2_i(lvl[0]), .wake_a1_i(pls[5]), .wake_a2_i(pls[4]),
    .done1_i(pls[3]), .done2_i(pls[2]), .sof_sent1_i(pls[1]), .sof_sent2_i(pls[0]),
    .dev_addr1_o(dev1), .dev_addr2_o(dev2), .irq1_o(irq1_o), .irq2_o(irq2_o),
    .frame_exp1_o(exp1), .frame_exp2_o(exp2));
  uhfir_usb_dev u_uhfir_usb_dev (.ref_clk_i(ref_clk_i), .lvl_o(lvl), .pls_o(pls));
  // free-running clock
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk_i) begin wr_i = 1; addr_i = a; wdata_i = d; end
    @(negedge ref_clk_i) wr_i = 0;
  endtask
  // data is looked at while the answer stands
  task rd(input logic [15:0] a, input logic [15:0] e, input string s);
    @(negedge ref_clk_i) begin rd_i = 1; addr_i = a; end
    @(negedge ref_clk_i) begin rd_i = 0; `CHK(s, e, rdata_o) end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard; the first default-length frame alone takes some 12000 cycles
  initial begin #200000; n_errors++; final_report; end
  initial begin
    addr_i  = 16'h0000;
    wdata_i = 16'h0000;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i) nrst_i = 1;
    rd(`UHFIR_H1_RELOAD, 16'h2ee0, "reload1");
    rd(`UHFIR_H2_FRAME, 16'h0000, "frame2");
    rd(16'hc0c0, 16'h0000, "unmapped");
    wr(`UHFIR_H1_ADDR, 16'h0055);
    wr(`UHFIR_H2_ADDR, 16'h007f);
    @(negedge ref_clk_i);
    `CHK("dev1", 7'h55, dev1)
    `CHK("dev2", 7'h7f, dev2)
    rd(`UHFIR_H1_ADDR, 16'h0000, "addr1");
    wr(`UHFIR_H1_IEN, 16'hc251);
    wr(`UHFIR_H2_IEN, 16'h0251);
    rd(`UHFIR_H1_IEN, 16'hc251, "ien1");
    rd(`UHFIR_H2_IEN, 16'h0251, "ien2");
    $display("test registers done");
    u_uhfir_usb_dev.pulse(6'h3c);
    rd(`UHFIR_H1_STAT, 16'h0041, "stat1 ev");
    rd(`UHFIR_H2_STAT, 16'h0041, "stat2 ev");
    `CHK("irq2", 1'b1, irq2_o)
    wr(`UHFIR_H1_STAT, 16'h0001);
    rd(`UHFIR_H1_STAT, 16'h0040, "stat1 clr");
    `CHK("irq1", 1'b1, irq1_o)
    wr(`UHFIR_H1_IEN, 16'h0000);
    wr(`UHFIR_H2_IEN, 16'h0000);
    `CHK("irq1 off", 1'b0, irq1_o)
    rd(`UHFIR_H1_STAT, 16'h0040, "stat1 kept");
    wr(`UHFIR_H1_STAT, 16'hc251);
    wr(`UHFIR_H2_STAT, 16'h0251);
    wr(`UHFIR_H1_IEN, 16'hc251);
    $display("test events done");
    u_uhfir_usb_dev.set_lvl(4'hf);
    repeat (5) @(negedge ref_clk_i);
    rd(`UHFIR_H1_STAT, 16'hc014, "stat1 pins");
    rd(`UHFIR_H2_STAT, 16'h0014, "stat2 pins");
    wr(`UHFIR_H1_STAT, 16'hc251);
    rd(`UHFIR_H1_STAT, 16'h0004, "stat1 se0");
    u_uhfir_usb_dev.set_lvl(4'h0);
    repeat (5) @(negedge ref_clk_i);
    rd(`UHFIR_H1_STAT, 16'hc010, "stat1 gone");
    wr(`UHFIR_H1_STAT, 16'hc251);
    $display("test lines done");
    u_uhfir_usb_dev.pulse(6'h02);
    rd(`UHFIR_H1_FRAME, 16'h0001, "frame1 sof");
    wr(`UHFIR_H1_RELOAD, 16'h0005);
    rd(`UHFIR_H1_FRAME, 16'h0000, "frame1 wr");
    rd(`UHFIR_H1_RELOAD, 16'h0005, "reload1 rd");
    // the running frame ends at the default length before the new reload applies
    for (n = 0; n < 13000 && exp1 !== 1'b1; n++) @(negedge ref_clk_i);
    `CHK("expire", 1'b1, exp1)
    `CHK("expire2", 1'b1, exp2)
    @(negedge ref_clk_i);
    for (n = 1; n < 20 && exp1 !== 1'b1; n++) @(negedge ref_clk_i);
    `CHK("period", 5, n)
    rd(`UHFIR_H1_LIVE, 16'h0004, "live1");
    rd(`UHFIR_H1_STAT, 16'h0200, "stat1 sof");
    $display("test frame done");
    final_report;
  end
endmodule // usb_host_frame_and_interrupt_regs_bench
`default_nettype wire
